// File: dv/pic_device_model.sv
// Behavioural model of the eight-input interrupt controller as seen on its pins.
// Assumes level triggering, fixed or rotating priority and strobes of at least four pclk cycles.
`timescale 1ns/10ps
`default_nettype none
module pic_device_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [8:0] chip_sel_n,
  input wire logic addr_line,
  input wire logic [7:0] data_out,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic acknowledge_strobe_n,
  input wire logic [7:0] request_out,
  output logic [7:0] data_in,
  output logic int_out,
  input wire logic data_oe_n
);
  // ****************************************
  // Priority and readback
  // ****************************************
  logic [7:0] mask_ff, service_ff, frozen_ff, byte_ff, last_ff, rd_byte;
  logic [3:0] gap_ff;
  logic [2:0] lvl_ff, low_lv_ff;
  logic a0_ff, sel_srv_ff, smm_ff, poll_ff, first_ff, ack_q_ff, rd_q_ff, wr_q_ff;
  // Highest-priority set bit, counting ranks from the level hi upwards with wrap.
  function automatic logic [2:0] pick(input logic [7:0] v, input logic [2:0] hi);
    pick = 3'h7;
    for (int i = 7; i >= 0; i--)
      if (v[3'(i) + hi]) pick = 3'(i) + hi;
  endfunction
  // Levels that rank strictly above level lv under the current rotation.
  function automatic logic [7:0] above(input logic [2:0] lv, input logic [2:0] hi);
    for (int i = 0; i < 8; i++)
      above[i] = (3'(i) - hi) < (lv - hi);
  endfunction
  wire logic sel = ~&chip_sel_n;
  wire logic [2:0] hi_lv = low_lv_ff + 3'h1;
  wire logic [2:0] srv_lv = pick(service_ff, hi_lv);
  wire logic [7:0] open_lv = (smm_ff || service_ff == 8'h00) ? 8'hff :
                             above(srv_lv, hi_lv);
  wire logic [7:0] elig = request_out & ~mask_ff & open_lv;
  wire logic drv = (!read_strobe_n && sel) || !acknowledge_strobe_n;
  assign rd_byte = !acknowledge_strobe_n ? (first_ff ? 8'hcd : {5'h02, lvl_ff}) :
                   poll_ff ? {|frozen_ff, 4'h0, pick(frozen_ff, hi_lv)} :
                   addr_line ? mask_ff : sel_srv_ff ? service_ff : request_out;
  // A released bus inverts its value every cycle, so the last driven byte reappears on alternate cycles.
  assign data_in = drv ? rd_byte : ~last_ff;
  assign int_out = |elig;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {mask_ff, service_ff, frozen_ff, byte_ff, last_ff} <= 40'h0;
      {a0_ff, sel_srv_ff, smm_ff, poll_ff} <= 4'h0;
      {first_ff, ack_q_ff, rd_q_ff, wr_q_ff} <= 4'hf;
      gap_ff <= 4'hf;
      lvl_ff <= 3'h0;
      low_lv_ff <= 3'h7;
    end else begin
      last_ff <= data_in;
      ack_q_ff <= acknowledge_strobe_n;
      rd_q_ff <= read_strobe_n;
      wr_q_ff <= write_strobe_n;
      gap_ff <= !acknowledge_strobe_n ? 4'h0 : (gap_ff == 4'hf ? gap_ff : gap_ff + 4'h1);
      // A long quiet gap marks the next acknowledge pulse as the first of a sequence.
      if (acknowledge_strobe_n) first_ff <= gap_ff > 4'h6;
      if (!acknowledge_strobe_n && ack_q_ff && first_ff) begin
        lvl_ff <= |elig ? pick(elig, hi_lv) : 3'h7;
        service_ff <= service_ff | (|elig ? 8'h01 << pick(elig, hi_lv) : 8'h00);
      end
      if (read_strobe_n && !rd_q_ff && poll_ff) begin
        poll_ff <= 1'b0;
        service_ff <= service_ff | (|frozen_ff ? 8'h01 << pick(frozen_ff, hi_lv) : 8'h00);
      end
      if (!write_strobe_n && sel) begin
        // An undriven bus reads as all ones, which decodes as a setup word and wrecks state.
        byte_ff <= data_oe_n ? 8'hff : data_out;
        a0_ff <= addr_line;
      end
      if (write_strobe_n && !wr_q_ff) begin
        if (a0_ff) mask_ff <= byte_ff;
        else if (byte_ff[4]) begin
          {mask_ff, service_ff} <= 16'h0;
          {sel_srv_ff, smm_ff} <= 2'h0;
          low_lv_ff <= 3'h7;
        end else if (byte_ff[3]) begin
          if (byte_ff[6]) smm_ff <= byte_ff[5];
          if (byte_ff[2]) begin
            poll_ff <= 1'b1;
            frozen_ff <= elig;
          end else if (byte_ff[1]) sel_srv_ff <= byte_ff[0];
        end else begin
          if (byte_ff[5])
            service_ff <= service_ff & ~(byte_ff[6] ? 8'h01 << byte_ff[2:0] : 8'h01 << srv_lv);
          if (byte_ff[7] && (byte_ff[6] || byte_ff[5]))
            low_lv_ff <= byte_ff[6] ? byte_ff[2:0] : srv_lv;
        end
      end
    end
  end
endmodule // pic_device_model
`default_nettype wire

// File: dv/priority_interrupt_controller_bench.sv
// Self-checking bench for the host sequencer of the priority interrupt controller.
// Assumes the device model on the pins and the sequencer's own APB register map.
`timescale 1ns/10ps
`default_nettype none
module priority_interrupt_controller_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_seen, int_in;
  logic [7:0] paddr, data_in, data_out, request_out;
  logic [31:0] pwdata, prdata, rd;
  logic data_oe_n, addr_line, read_strobe_n, write_strobe_n, acknowledge_strobe_n;
  logic [8:0] chip_sel_n;
  int n_errors, cmp_count;
  pic_host dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .data_in, .data_out, .data_oe_n, .addr_line, .chip_sel_n, .read_strobe_n,
    .write_strobe_n, .acknowledge_strobe_n, .int_in, .request_out);
  pic_device_model dev (.pclk, .presetn, .chip_sel_n, .addr_line, .data_out, .read_strobe_n,
    .write_strobe_n, .acknowledge_strobe_n, .request_out, .data_in, .int_out(int_in),
    .data_oe_n);
  // ****************************************
  // Tasks
  // ****************************************
  task automatic final_report;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Each rising edge is looked at before its own updates land, as the slave sees it.
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 400);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      final_report();
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask
  task automatic cmd(input logic [1:0] k, input logic [3:0] chip, input logic a0,
                     input logic [7:0] b);
    int n;
    apb(pic_host_pkg::CMD_OFF, 1'b1, {17'h0, k, chip, a0, b});
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 100) begin
      apb(pic_host_pkg::STAT_OFF, 1'b0, 32'h0);
      n++;
    end
    if (n >= 100) begin
      n_errors++;
      final_report();
    end
  endtask
  task automatic devrd(input logic a0, input logic [7:0] e);
    cmd(2'h1, 4'h0, a0, 8'h00);
    rdchk(pic_host_pkg::RDATA_OFF, {24'h0, e});
  endtask
  // The interrupt level crosses a two-flop synchroniser before it shows in status.
  task automatic stbit(input int i, input logic e);
    repeat (4) @(posedge pclk);
    apb(pic_host_pkg::STAT_OFF, 1'b0, 32'h0);
    check({31'h0, rd[i]}, {31'h0, e});
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_errors = 0;
    cmp_count = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(pic_host_pkg::CFG_OFF, {16'h0, pic_host_pkg::CFG_RST});
    rdchk(pic_host_pkg::CMD_OFF, {17'h0, pic_host_pkg::CMD_RST});
    apb(8'h20, 1'b0, 32'h0);
    check({31'h0, err_seen}, 32'h1);
    cmd(2'h0, 4'h0, 1'b0, 8'h1b);
    cmd(2'h0, 4'h0, 1'b1, 8'h5a);
    devrd(1'b1, 8'h5a);
    apb(pic_host_pkg::REQ_OFF, 1'b1, 32'h24);
    cmd(2'h0, 4'h0, 1'b1, 8'h00);
    devrd(1'b0, 8'h24);
    stbit(1, 1'b1);
    cmd(2'h0, 4'h0, 1'b1, 8'h24);
    stbit(1, 1'b0);
    cmd(2'h0, 4'h0, 1'b1, 8'h00);
    apb(pic_host_pkg::CFG_OFF, 1'b1, 32'h0400);
    cmd(2'h2, 4'h0, 1'b0, 8'h00);
    rdchk(pic_host_pkg::RDATA_OFF, 32'h00cd1212);
    rdchk(pic_host_pkg::REQ_OFF, 32'h20);
    cmd(2'h0, 4'h0, 1'b0, 8'h0b);
    devrd(1'b0, 8'h04);
    stbit(1, 1'b0);
    cmd(2'h0, 4'h0, 1'b0, 8'h68);
    stbit(1, 1'b1);
    cmd(2'h0, 4'h0, 1'b0, 8'h20);
    stbit(pic_host_pkg::STAT_ERR_BIT, 1'b1);
    apb(pic_host_pkg::STAT_OFF, 1'b1, 32'h4);
    stbit(pic_host_pkg::STAT_ERR_BIT, 1'b0);
    devrd(1'b0, 8'h04);
    cmd(2'h0, 4'h0, 1'b0, 8'h62);
    devrd(1'b0, 8'h00);
    cmd(2'h0, 4'h0, 1'b0, 8'h48);
    cmd(2'h0, 4'h0, 1'b0, 8'h0c);
    devrd(1'b0, 8'h85);
    cmd(2'h0, 4'h0, 1'b0, 8'h0b);
    devrd(1'b0, 8'h20);
    cmd(2'h0, 4'h0, 1'b0, 8'h20);
    devrd(1'b0, 8'h00);
    apb(pic_host_pkg::REQ_OFF, 1'b1, 32'h00);
    cmd(2'h2, 4'h0, 1'b0, 8'h00);
    rdchk(pic_host_pkg::RDATA_OFF, 32'h00cd1717);
    devrd(1'b0, 8'h00);
    apb(pic_host_pkg::CFG_OFF, 1'b1, 32'hff01);
    apb(pic_host_pkg::REQ_OFF, 1'b1, 32'h02);
    cmd(2'h2, 4'h0, 1'b0, 8'h00);
    rdchk(pic_host_pkg::RDATA_OFF, 32'h0000cd11);
    apb(pic_host_pkg::REQ_OFF, 1'b1, 32'h01);
    cmd(2'h2, 4'h0, 1'b0, 8'h00);
    devrd(1'b0, 8'h03);
    cmd(2'h3, 4'h1, 1'b0, 8'h00);
    stbit(3, 1'b0);
    devrd(1'b0, 8'h02);
    cmd(2'h3, 4'h1, 1'b0, 8'h00);
    stbit(3, 1'b1);
    devrd(1'b0, 8'h00);
    cmd(2'h0, 4'h0, 1'b0, 8'hc4);
    apb(pic_host_pkg::REQ_OFF, 1'b1, 32'h21);
    cmd(2'h0, 4'h0, 1'b0, 8'h0c);
    devrd(1'b0, 8'h85);
    cmd(2'h0, 4'h0, 1'b0, 8'he5);
    cmd(2'h0, 4'h0, 1'b0, 8'h0c);
    devrd(1'b0, 8'h80);
    cmd(2'h0, 4'h0, 1'b0, 8'ha0);
    cmd(2'h0, 4'h0, 1'b0, 8'h0c);
    devrd(1'b0, 8'h85);
    final_report();
  end
endmodule // priority_interrupt_controller_bench
`default_nettype wire

// File: hdl/pic_host.sv
// Host sequencer that drives the interrupt controller pins on orders given over APB.
// Assumes one master device on chip select 0 and up to eight slaves on selects 1 to 8.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - host uses specific END_OF_SERVICE_COMMAND in special mask; exit jobs still send the non-specific NONSPEC_EOI
// - source holds request until first acknowledge
// - slave END_OF_SERVICE_COMMAND, read service, then master END_OF_SERVICE_COMMAND
// - master serves eight slaves over cascade
module pic_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  output logic addr_line,
  output logic [8:0] chip_sel_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic acknowledge_strobe_n,
  input wire logic int_in,
  output logic [7:0] request_out
);

  // ****************************************
  // State
  // ****************************************
  pic_host_pkg::seq_state_t st_ff, nxt_st;
  pic_host_pkg::job_t job_ff;
  logic [pic_host_pkg::CMD_W-1:0] cmd_ff;
  logic [15:0] cfg_ff;
  logic [1:0] step_ff, nxt_step;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [23:0] rd_data_ff;
  logic [7:0] request_out_ff, nxt_req;
  logic smm_ff, err_ff, master_eoi_ff;
  logic [7:0] data_s;
  logic int_s;

  two_flop_sync #(.W(8)) u_data_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(data_in),
    .q(data_s)
  );

  two_flop_sync #(.W(1)) u_int_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(int_in),
    .q(int_s)
  );

  // ****************************************
  // APB decode
  // ****************************************
  wire busy = (st_ff != pic_host_pkg::ST_IDLE);
  wire cmd_hit = (paddr == pic_host_pkg::CMD_OFF);
  wire stat_hit = (paddr == pic_host_pkg::STAT_OFF);
  wire rdata_hit = (paddr == pic_host_pkg::RDATA_OFF);
  wire req_hit = (paddr == pic_host_pkg::REQ_OFF);
  wire cfg_hit = (paddr == pic_host_pkg::CFG_OFF);
  wire any_hit = cmd_hit | stat_hit | rdata_hit | req_hit | cfg_hit;
  // A new command waits in the access phase until the previous one has finished.
  assign pready = !(psel && cmd_hit && pwrite && busy);
  assign pslverr = psel && penable && !any_hit;
  wire wr_acc = psel && penable && pwrite && pready && any_hit;
  wire cmd_wr = wr_acc && cmd_hit;
  wire stat_wr = wr_acc && stat_hit;
  wire req_wr = wr_acc && req_hit;
  wire cfg_wr = wr_acc && cfg_hit;

  wire [1:0] new_kind = pwdata[pic_host_pkg::CMD_KIND_LSB +: 2];
  wire new_a0 = pwdata[pic_host_pkg::CMD_A0_BIT];
  wire [7:0] new_data = pwdata[7:0];
  wire new_is_wr = (new_kind == 2'(pic_host_pkg::JOB_WR));
  wire new_prio = new_is_wr && !new_a0 && (new_data[4:3] == pic_host_pkg::SEL_PRIO);
  wire new_readback = new_is_wr && !new_a0 && (new_data[4:3] == pic_host_pkg::SEL_READBACK);
  wire new_nonspec = (new_data[7:5] == pic_host_pkg::EOI_NONSPEC) ||
                     (new_data[7:5] == pic_host_pkg::EOI_ROT_NONSPEC);
  // Non-specific END_OF_SERVICE_COMMAND under special mask mode could clear a masked level; refuse it.
  wire refuse = smm_ff && new_prio && new_nonspec;
  wire go = cmd_wr && !refuse;

  assign prdata = cmd_hit ? {17'h0, cmd_ff} :
                  stat_hit ? {28'h0, master_eoi_ff, err_ff, int_s, busy} :
                  rdata_hit ? {8'h0, rd_data_ff} :
                  req_hit ? {24'h0, request_out_ff} :
                  cfg_hit ? {16'h0, cfg_ff} : 32'h0;

  // ****************************************
  // Step decode
  // ****************************************
  wire [7:0] cmd_data = cmd_ff[7:0];
  wire [3:0] cmd_chip = cmd_ff[pic_host_pkg::CMD_CHIP_LSB +: 4];
  wire [1:0] ack_pulses = cfg_ff[pic_host_pkg::CFG_VEC_BIT] ? pic_host_pkg::PULSES_VECTOR :
                          pic_host_pkg::PULSES_CALL;
  wire is_exit = (job_ff == pic_host_pkg::JOB_EXIT);
  wire is_ack = (job_ff == pic_host_pkg::JOB_ACK);
  wire step_rd = (job_ff == pic_host_pkg::JOB_RD) || (is_exit && step_ff == 2'h2);
  wire step_wr = (job_ff == pic_host_pkg::JOB_WR) || (is_exit && step_ff != 2'h2);
  // Exit sequence: slave END_OF_SERVICE_COMMAND, select service register, read it, master END_OF_SERVICE_COMMAND if empty.
  wire [3:0] step_chip = (is_exit && step_ff == pic_host_pkg::EXIT_LAST) ?
                         pic_host_pkg::MASTER_CHIP : cmd_chip;
  wire [7:0] step_data = !is_exit ? cmd_data :
                         (step_ff == 2'h1) ? pic_host_pkg::READ_SERVICE :
                         pic_host_pkg::NONSPEC_EOI;
  wire step_a0 = is_exit ? 1'b0 : cmd_ff[pic_host_pkg::CMD_A0_BIT];
  wire last_step = is_ack ? (step_ff == ack_pulses - 2'h1) :
                   is_exit ? (step_ff == pic_host_pkg::EXIT_LAST ||
                              (step_ff == 2'h2 && rd_data_ff[7:0] != 8'h00)) :
                   1'b1;
  wire strobe_end = (st_ff == pic_host_pkg::ST_ASSERT) && (cnt_ff == 4'h0);
  wire nxt_active = (nxt_st == pic_host_pkg::ST_SETUP) || (nxt_st == pic_host_pkg::ST_ASSERT);
  wire nxt_strobe = (nxt_st == pic_host_pkg::ST_ASSERT);

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_step = step_ff;
    nxt_cnt = cnt_ff;
    unique case (st_ff)
      pic_host_pkg::ST_IDLE: begin
        if (go) begin
          nxt_st = pic_host_pkg::ST_SETUP;
          nxt_step = 2'h0;
        end
      end
      pic_host_pkg::ST_SETUP: begin
        nxt_st = pic_host_pkg::ST_ASSERT;
        nxt_cnt = pic_host_pkg::STROBE_LAST;
      end
      pic_host_pkg::ST_ASSERT: begin
        if (cnt_ff == 4'h0) begin
          nxt_st = pic_host_pkg::ST_GAP;
          nxt_cnt = pic_host_pkg::RECOVER_LAST;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      pic_host_pkg::ST_GAP: begin
        if (cnt_ff != 4'h0) begin
          nxt_cnt = cnt_ff - 4'h1;
        end else if (last_step) begin
          nxt_st = pic_host_pkg::ST_IDLE;
        end else begin
          nxt_st = pic_host_pkg::ST_SETUP;
          nxt_step = step_ff + 2'h1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= pic_host_pkg::ST_IDLE;
      step_ff <= 2'h0;
      cnt_ff <= 4'h0;
    end else begin
      st_ff <= nxt_st;
      step_ff <= nxt_step;
      cnt_ff <= nxt_cnt;
    end
  end

  // ****************************************
  // Pins
  // ****************************************
  // Acknowledge pulses carry no chip select; the master steers slaves by cascade.
  wire [8:0] sel_onehot = 9'h001 << step_chip;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_sel_n <= 9'h1ff;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      acknowledge_strobe_n <= 1'b1;
      data_oe_n <= 1'b1;
      data_out <= 8'h00;
      addr_line <= 1'b0;
    end else begin
      chip_sel_n <= (nxt_active && !is_ack) ? ~sel_onehot : 9'h1ff;
      read_strobe_n <= !(nxt_strobe && step_rd);
      write_strobe_n <= !(nxt_strobe && step_wr);
      acknowledge_strobe_n <= !(nxt_strobe && is_ack);
      data_oe_n <= !(nxt_active && step_wr);
      data_out <= step_data;
      addr_line <= step_a0;
    end
  end

  // ****************************************
  // Command, config and captured data
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ff <= pic_host_pkg::CMD_RST;
      job_ff <= pic_host_pkg::JOB_WR;
      cfg_ff <= pic_host_pkg::CFG_RST;
    end else begin
      if (go) begin
        cmd_ff <= pwdata[pic_host_pkg::CMD_W-1:0];
        job_ff <= pic_host_pkg::job_t'(new_kind);
      end
      if (cfg_wr) begin
        cfg_ff <= pwdata[15:0];
      end
    end
  end

  // Read and acknowledge bytes shift in at the rising strobe, newest in the low byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_ff <= 24'h000000;
    end else if (go) begin
      rd_data_ff <= 24'h000000;
    end else if (strobe_end && (step_rd || is_ack)) begin
      rd_data_ff <= {rd_data_ff[15:0], data_s};
    end
  end

  // Special mask mode is tracked from readback words so END_OF_SERVICE_COMMAND can be screened.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smm_ff <= 1'b0;
    end else if (go && new_readback && new_data[pic_host_pkg::SPECIAL_MASK_CHANGE_ENABLE_BIT]) begin
      smm_ff <= new_data[pic_host_pkg::SMM_BIT];
    end
  end

  // Error and master-END_OF_SERVICE_COMMAND flags: a new set wins over a clear in the same cycle.
  wire exit_master = is_exit && step_ff == pic_host_pkg::EXIT_LAST && strobe_end;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_ff <= 1'b0;
      master_eoi_ff <= 1'b0;
    end else begin
      err_ff <= (cmd_wr && refuse) ||
                (err_ff && !(stat_wr && pwdata[pic_host_pkg::STAT_ERR_BIT]));
      master_eoi_ff <= exit_master || (master_eoi_ff && !go);
    end
  end

  // ****************************************
  // Request sources
  // ****************************************
  // In the setup cycle before the first acknowledge falls, software may raise but not drop requests.
  wire hold_lock = is_ack && step_ff == 2'h0 && st_ff == pic_host_pkg::ST_SETUP;
  wire withdraw_now = is_ack && step_ff == 2'h0 && st_ff == pic_host_pkg::ST_ASSERT &&
                      cnt_ff == pic_host_pkg::STROBE_LAST;
  wire [7:0] req_written = !req_wr ? request_out_ff :
                           hold_lock ? (request_out_ff | pwdata[7:0]) : pwdata[7:0];
  assign nxt_req = withdraw_now ? (req_written & ~cfg_ff[pic_host_pkg::CFG_WD_LSB +: 8]) :
                   req_written;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      request_out_ff <= 8'h00;
    end else begin
      request_out_ff <= nxt_req;
    end
  end
  assign request_out = request_out_ff;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  hold_req_a:
    assert property (hold_lock |=>
      ((request_out_ff & $past(request_out_ff)) == $past(request_out_ff)))
    else $error("request dropped before the first acknowledge pulse");

  eoi_refuse_a:
    assert property ((cmd_wr && refuse) |=> (err_ff && st_ff == pic_host_pkg::ST_IDLE))
    else $error("non-specific END_OF_SERVICE_COMMAND issued under special mask mode");

  exit_order_a:
    assert property ((is_exit && step_ff == pic_host_pkg::EXIT_LAST &&
                      st_ff == pic_host_pkg::ST_SETUP) |->
                     (rd_data_ff[7:0] == 8'h00 && step_chip == pic_host_pkg::MASTER_CHIP))
    else $error("master END_OF_SERVICE_COMMAND sent while slave service register not empty");

  ack_count_a:
    assert property ((st_ff == pic_host_pkg::ST_ASSERT && is_ack) |->
                     (step_ff < ack_pulses && chip_sel_n == 9'h1ff))
    else $error("acknowledge pulse count or chip select wrong");

  ack_width_a:
    assert property ($fell(acknowledge_strobe_n) |-> !acknowledge_strobe_n [*4] ##1
                     acknowledge_strobe_n)
    else $error("acknowledge pulse width wrong");

  ack_done_c: cover property (is_ack && last_step && strobe_end);
  exit_master_c: cover property (exit_master);
  refuse_c: cover property (cmd_wr && refuse);
  poll_read_c: cover property (job_ff == pic_host_pkg::JOB_RD && strobe_end);

endmodule // pic_host
`default_nettype wire

// File: hdl/pic_host_pkg.sv
// Constants shared by the host sequencer for the eight-input priority interrupt controller.
// Assumes a 25 MHz pclk and an 8-bit device bus with one address line.
package pic_host_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 40;
  localparam int STROBE_NS = 160;
  localparam int RECOVER_NS = 200;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);
  localparam logic [3:0] RECOVER_LAST = 4'(RECOVER_CYC - 1);

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [7:0] CMD_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] RDATA_OFF = 8'h08;
  localparam logic [7:0] REQ_OFF = 8'h0c;
  localparam logic [7:0] CFG_OFF = 8'h10;
  localparam int CMD_A0_BIT = 8;
  localparam int CMD_CHIP_LSB = 9;
  localparam int CMD_KIND_LSB = 13;
  localparam int CMD_W = 15;
  localparam int STAT_ERR_BIT = 2;
  localparam int CFG_VEC_BIT = 0;
  localparam int CFG_WD_LSB = 8;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [CMD_W-1:0] CMD_RST = 15'h0000;

  // ****************************************
  // Device command words
  // ****************************************
  localparam logic [7:0] NONSPEC_EOI = 8'h20;
  localparam logic [7:0] READ_SERVICE = 8'h0b;
  localparam logic [1:0] SEL_PRIO = 2'h0;
  localparam logic [1:0] SEL_READBACK = 2'h1;
  localparam logic [2:0] EOI_NONSPEC = 3'h1;
  localparam logic [2:0] EOI_ROT_NONSPEC = 3'h5;
  localparam int SPECIAL_MASK_CHANGE_ENABLE_BIT = 6;
  localparam int SMM_BIT = 5;
  localparam logic [3:0] MASTER_CHIP = 4'h0;
  localparam logic [1:0] PULSES_VECTOR = 2'h2;
  localparam logic [1:0] PULSES_CALL = 2'h3;
  localparam logic [1:0] EXIT_LAST = 2'h3;

  typedef enum logic [1:0] {JOB_WR, JOB_RD, JOB_ACK, JOB_EXIT} job_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_ASSERT, ST_GAP} seq_state_t;

endpackage

// File: hdl/two_flop_sync.sv
// Two-stage synchroniser for levels arriving from outside the pclk domain.
// Assumes the consumer tolerates two cycles of latency.
`timescale 1ns/10ps
`default_nettype none
module two_flop_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule // two_flop_sync
`default_nettype wire
